/* File: core/pwm_capture_pkg.sv */
// constants, register map and channel configuration carrier for the
// eight-channel pwm and capture timer.
// assumes word-addressed register port with 32-bit data.
package pwm_capture_pkg;

	// ***************************************************
	// sizes
	// ***************************************************
	localparam int CHANNELS = 8;
	localparam int CNT_W = 16;
	localparam int PRESC_W = 8;
	localparam int DEAD_W = 8;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;

	// ***************************************************
	// register map (word index)
	// ***************************************************
	// channel n owns indices n*8 .. n*8+7, status sits above them
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_PRESC = 3'h1;
	localparam logic [2:0] REG_PERIOD = 3'h2;
	localparam logic [2:0] REG_CMP_A = 3'h3;
	localparam logic [2:0] REG_CMP_B = 3'h4;
	localparam logic [2:0] REG_DEAD = 3'h5;
	localparam logic [2:0] REG_CAPT = 3'h6;
	localparam logic [2:0] REG_COUNT = 3'h7;
	localparam logic [ADDR_W-1:0] REG_STATUS = 7'h40;

	// ***************************************************
	// control word fields
	// ***************************************************
	localparam int CTRL_EN = 0;
	localparam int CTRL_COMP = 1;
	localparam int CTRL_POL_A = 2;
	localparam int CTRL_POL_B = 3;
	localparam int CTRL_CAP_EN = 4;
	localparam int CTRL_EDGE_LO = 5;
	localparam int CTRL_DIV_LO = 8;
	localparam int STAT_CAP_LO = 8;

	typedef enum logic [1:0] {
		EDGE_RISE = 2'b00,
		EDGE_FALL = 2'b01,
		EDGE_BOTH = 2'b10,
		EDGE_BOTH2 = 2'b11
	} edge_sel_e;

	typedef enum logic [2:0] {
		DIV_1 = 3'b000,
		DIV_2 = 3'b001,
		DIV_4 = 3'b010,
		DIV_8 = 3'b011,
		DIV_16 = 3'b100
	} div_sel_e;

	typedef struct packed {
		logic enable;
		logic comp_mode;
		logic pol_a;
		logic pol_b;
		logic cap_en;
		logic [1:0] edge_sel;
		logic [2:0] div_sel;
		logic [PRESC_W-1:0] presc;
		logic [CNT_W-1:0] period;
		logic [CNT_W-1:0] cmp_a;
		logic [CNT_W-1:0] cmp_b;
		logic [DEAD_W-1:0] dead;
	} chan_cfg_s;

	localparam chan_cfg_s CFG_RESET = '0;

endpackage

/* File: core/pwm_channel.sv */
// one pwm channel: prescaler, divider, counter, compare, dead time,
// polarity and edge capture.
// assumes cap_in is already synchronised to core_clk.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
	import pwm_capture_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire pwm_capture_pkg::chan_cfg_s cfg,
	input wire logic cap_in,
	output logic out_a_r,
	output logic out_b_r,
	output logic [pwm_capture_pkg::CNT_W-1:0] cnt_r,
	output logic [pwm_capture_pkg::CNT_W-1:0] capt_r,
	output logic wrap_r,
	output logic cap_hit_r
);
	import pwm_capture_pkg::*;

	logic [PRESC_W-1:0] pre_cnt_r;
	logic [3:0] div_cnt_r;
	logic [3:0] div_mask;
	logic pre_tick;
	logic cnt_tick;
	logic raw_a;
	logic raw_b;
	logic prev_raw_r;
	logic [DEAD_W-1:0] dt_cnt_r;
	logic cap_prev_r;
	logic cap_edge;
	logic act_a;
	logic act_b;

	// ***************************************************
	// clock chain
	// ***************************************************
	// prescaler value n divides by n+1, so 0 passes every cycle
	assign pre_tick = cfg.enable && (pre_cnt_r == cfg.presc);

	always_comb begin
		unique case (cfg.div_sel)
			DIV_1: div_mask = 4'h0;
			DIV_2: div_mask = 4'h1;
			DIV_4: div_mask = 4'h3;
			DIV_8: div_mask = 4'h7;
			default: div_mask = 4'hf;
		endcase
	end
	assign cnt_tick = pre_tick && ((div_cnt_r & div_mask) == div_mask);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_cnt_r <= '0;
		end else if (!cfg.enable || pre_tick) begin
			pre_cnt_r <= '0;
		end else begin
			pre_cnt_r <= pre_cnt_r + 8'h1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_cnt_r <= '0;
		end else if (!cfg.enable) begin
			div_cnt_r <= '0;
		end else if (pre_tick) begin
			div_cnt_r <= div_cnt_r + 4'h1;
		end
	end

	// ***************************************************
	// counter and compare
	// ***************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (!cfg.enable) begin
			cnt_r <= '0;
		end else if (cnt_tick) begin
			if (cnt_r >= cfg.period) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 16'h1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrap_r <= 1'b0;
		end else begin
			wrap_r <= cnt_tick && (cnt_r >= cfg.period);
		end
	end

	// level rises at wrap, falls at compare match
	assign raw_a = cnt_r < cfg.cmp_a;
	assign raw_b = cnt_r < cfg.cmp_b;

	// ***************************************************
	// dead time
	// ***************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_raw_r <= 1'b0;
		end else begin
			prev_raw_r <= raw_a;
		end
	end

	// any toggle of the shared level reloads the gap, both sides idle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dt_cnt_r <= '0;
		end else if (raw_a != prev_raw_r) begin
			dt_cnt_r <= cfg.dead;
		end else if (cnt_tick && dt_cnt_r != '0) begin
			dt_cnt_r <= dt_cnt_r - 8'h1;
		end
	end

	always_comb begin
		if (cfg.comp_mode) begin
			act_a = raw_a && (raw_a == prev_raw_r) && (dt_cnt_r == '0);
			act_b = !raw_a && (raw_a == prev_raw_r) && (dt_cnt_r == '0);
		end else begin
			act_a = raw_a;
			act_b = raw_b;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			out_a_r <= 1'b0;
			out_b_r <= 1'b0;
		end else begin
			out_a_r <= (cfg.enable && act_a) ^ cfg.pol_a;
			out_b_r <= (cfg.enable && act_b) ^ cfg.pol_b;
		end
	end

	// ***************************************************
	// capture
	// ***************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cap_prev_r <= 1'b0;
		end else begin
			cap_prev_r <= cap_in;
		end
	end

	always_comb begin
		unique case (cfg.edge_sel)
			EDGE_RISE: cap_edge = cap_in && !cap_prev_r;
			EDGE_FALL: cap_edge = !cap_in && cap_prev_r;
			default: cap_edge = cap_in != cap_prev_r;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			capt_r <= '0;
			cap_hit_r <= 1'b0;
		end else begin
			cap_hit_r <= cfg.enable && cfg.cap_en && cap_edge;
			if (cfg.enable && cfg.cap_en && cap_edge) begin
				capt_r <= cnt_r;
			end
		end
	end

endmodule
`default_nettype wire

/* File: core/pwm_capture_timer.sv */
// top of the eight-channel pwm generator and capture timer: register
// port, status flags, input synchronisers and the channel array.
// assumes a single-cycle strobe master on core_clk; capture inputs are
// asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module pwm_capture_timer
	import pwm_capture_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [pwm_capture_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pwm_capture_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pwm_capture_pkg::DATA_W-1:0] reg_rdata_r,
	input wire logic [pwm_capture_pkg::CHANNELS-1:0] cap_pin,
	output logic [pwm_capture_pkg::CHANNELS-1:0] pwm_a,
	output logic [pwm_capture_pkg::CHANNELS-1:0] pwm_b,
	output logic [pwm_capture_pkg::CHANNELS-1:0] irq_r,
	output logic [pwm_capture_pkg::CHANNELS-1:0] cap_flag_r
);
	import pwm_capture_pkg::*;

	chan_cfg_s cfg_r [CHANNELS];
	logic [CNT_W-1:0] cnt [CHANNELS];
	logic [CNT_W-1:0] capt [CHANNELS];
	logic [CHANNELS-1:0] wrap;
	logic [CHANNELS-1:0] cap_hit;
	logic [CHANNELS-1:0] cap_meta_r;
	logic [CHANNELS-1:0] cap_sync_r;
	logic [2:0] sel_ch;
	logic [2:0] sel_reg;
	logic is_chan;
	logic status_wr;
	logic [DATA_W-1:0] rdata_nxt;

	assign sel_ch = reg_addr[5:3];
	assign sel_reg = reg_addr[2:0];
	assign is_chan = !reg_addr[6];
	assign status_wr = reg_wr && (reg_addr == REG_STATUS);

	// ***************************************************
	// input synchronisers
	// ***************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cap_meta_r <= '0;
			cap_sync_r <= '0;
		end else begin
			cap_meta_r <= cap_pin;
			cap_sync_r <= cap_meta_r;
		end
	end

	// ***************************************************
	// channels
	// ***************************************************
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_ch
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					cfg_r[g] <= CFG_RESET;
				end else if (reg_wr && is_chan && sel_ch == 3'(g)) begin
					unique case (sel_reg)
						REG_CTRL: begin
							cfg_r[g].enable <= reg_wdata[CTRL_EN];
							cfg_r[g].comp_mode <= reg_wdata[CTRL_COMP];
							cfg_r[g].pol_a <= reg_wdata[CTRL_POL_A];
							cfg_r[g].pol_b <= reg_wdata[CTRL_POL_B];
							cfg_r[g].cap_en <= reg_wdata[CTRL_CAP_EN];
							cfg_r[g].edge_sel <= reg_wdata[CTRL_EDGE_LO +: 2];
							cfg_r[g].div_sel <= reg_wdata[CTRL_DIV_LO +: 3];
						end
						REG_PRESC: cfg_r[g].presc <= reg_wdata[PRESC_W-1:0];
						REG_PERIOD: cfg_r[g].period <= reg_wdata[CNT_W-1:0];
						REG_CMP_A: cfg_r[g].cmp_a <= reg_wdata[CNT_W-1:0];
						REG_CMP_B: cfg_r[g].cmp_b <= reg_wdata[CNT_W-1:0];
						REG_DEAD: cfg_r[g].dead <= reg_wdata[DEAD_W-1:0];
						default: ;
					endcase
				end
			end

			pwm_channel u_ch (
				.core_clk(core_clk),
				.rst(rst),
				.cfg(cfg_r[g]),
				.cap_in(cap_sync_r[g]),
				.out_a_r(pwm_a[g]),
				.out_b_r(pwm_b[g]),
				.cnt_r(cnt[g]),
				.capt_r(capt[g]),
				.wrap_r(wrap[g]),
				.cap_hit_r(cap_hit[g])
			);

			// write one to clear; a new event in the same cycle wins
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					irq_r[g] <= 1'b0;
					cap_flag_r[g] <= 1'b0;
				end else begin
					if (wrap[g]) begin
						irq_r[g] <= 1'b1;
					end else if (status_wr && reg_wdata[g]) begin
						irq_r[g] <= 1'b0;
					end
					if (cap_hit[g]) begin
						cap_flag_r[g] <= 1'b1;
					end else if (status_wr && reg_wdata[STAT_CAP_LO + g]) begin
						cap_flag_r[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ***************************************************
	// read port
	// ***************************************************
	always_comb begin
		rdata_nxt = '0;
		if (reg_addr == REG_STATUS) begin
			rdata_nxt[CHANNELS-1:0] = irq_r;
			rdata_nxt[STAT_CAP_LO +: CHANNELS] = cap_flag_r;
		end else if (is_chan) begin
			unique case (sel_reg)
				REG_CTRL: begin
					rdata_nxt[CTRL_EN] = cfg_r[sel_ch].enable;
					rdata_nxt[CTRL_COMP] = cfg_r[sel_ch].comp_mode;
					rdata_nxt[CTRL_POL_A] = cfg_r[sel_ch].pol_a;
					rdata_nxt[CTRL_POL_B] = cfg_r[sel_ch].pol_b;
					rdata_nxt[CTRL_CAP_EN] = cfg_r[sel_ch].cap_en;
					rdata_nxt[CTRL_EDGE_LO +: 2] = cfg_r[sel_ch].edge_sel;
					rdata_nxt[CTRL_DIV_LO +: 3] = cfg_r[sel_ch].div_sel;
				end
				REG_PRESC: rdata_nxt[PRESC_W-1:0] = cfg_r[sel_ch].presc;
				REG_PERIOD: rdata_nxt[CNT_W-1:0] = cfg_r[sel_ch].period;
				REG_CMP_A: rdata_nxt[CNT_W-1:0] = cfg_r[sel_ch].cmp_a;
				REG_CMP_B: rdata_nxt[CNT_W-1:0] = cfg_r[sel_ch].cmp_b;
				REG_DEAD: rdata_nxt[DEAD_W-1:0] = cfg_r[sel_ch].dead;
				REG_CAPT: rdata_nxt[CNT_W-1:0] = capt[sel_ch];
				REG_COUNT: rdata_nxt[CNT_W-1:0] = cnt[sel_ch];
				default: ;
			endcase
		end
	end

	// data valid only in the cycle after the read strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= '0;
		end else if (reg_rd) begin
			reg_rdata_r <= rdata_nxt;
		end else begin
			reg_rdata_r <= '0;
		end
	end

endmodule
`default_nettype wire

/* File: tb/pwm_capture_timer_properties.sv */
// checker on the pwm capture timer ports
// assumes one clock and an async high reset
`timescale 1ns/1ps
`default_nettype none
module pwm_capture_timer_properties
	import pwm_capture_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [pwm_capture_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pwm_capture_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [pwm_capture_pkg::DATA_W-1:0] reg_rdata_r,
	input wire logic [pwm_capture_pkg::CHANNELS-1:0] cap_pin,
	input wire logic [pwm_capture_pkg::CHANNELS-1:0] pwm_a,
	input wire logic [pwm_capture_pkg::CHANNELS-1:0] pwm_b,
	input wire logic [pwm_capture_pkg::CHANNELS-1:0] irq_r,
	input wire logic [pwm_capture_pkg::CHANNELS-1:0] cap_flag_r
);
	import pwm_capture_pkg::*;
	// ****************
	// shadow and rules
	// ****************
	logic [CHANNELS-1:0] comp_r;
	logic [CHANNELS-1:0] comp_d_r;
	wire logic st_wr = reg_wr && reg_addr == REG_STATUS;
	// only uninverted complementary pairs are watched; inverted idle
	// levels may legally both be high. second stage lines the shadow
	// up with the registered outputs, which lag the config by a cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			comp_r <= '0;
			comp_d_r <= '0;
		end else begin
			comp_d_r <= comp_r;
			if (reg_wr && !reg_addr[6] && reg_addr[2:0] == REG_CTRL)
				comp_r[reg_addr[5:3]] <= reg_wdata[CTRL_COMP]
					&& !reg_wdata[CTRL_POL_A]
					&& !reg_wdata[CTRL_POL_B];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == '0)
		else $error("read data not idle");
	a_unmapped_zero: assert property ($past(reg_rd && reg_addr[6]
		&& reg_addr != REG_STATUS) |-> reg_rdata_r == '0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property ($past(reg_rd && !reg_addr[6])
		|-> reg_rdata_r[31:16] == 16'h0)
		else $error("upper read bits set");
	a_status_read: assert property ($past(reg_rd && st_wr == 1'b0
		&& reg_addr == REG_STATUS) |-> reg_rdata_r ==
		{16'h0, $past(cap_flag_r), $past(irq_r)})
		else $error("status read wrong");
	a_irq_sticky: assert property ((($past(irq_r) & ~irq_r) &
		~($past(reg_wdata[7:0]) & {8{$past(st_wr)}})) == 8'h0)
		else $error("wrap flag dropped");
	a_cap_sticky: assert property ((($past(cap_flag_r) & ~cap_flag_r)
		& ~($past(reg_wdata[15:8]) & {8{$past(st_wr)}})) == 8'h0)
		else $error("capture flag dropped");
	a_comp_overlap: assert property ((pwm_a & pwm_b & comp_d_r) == '0)
		else $error("paired outputs overlap");
	a_reset_quiet: assert property ($fell(rst) |-> (pwm_a | pwm_b
		| irq_r | cap_flag_r) == '0)
		else $error("outputs active after reset");
endmodule
bind pwm_capture_timer pwm_capture_timer_properties
	u_pwm_capture_timer_properties (.core_clk(core_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .cap_pin(cap_pin),
	.pwm_a(pwm_a), .pwm_b(pwm_b), .irq_r(irq_r), .cap_flag_r(cap_flag_r));
`default_nettype wire

/* File: tb/tb_pwm_capture_timer.sv */
// self-checking bench for the pwm capture timer
// assumes the checker is bound into the design
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_capture_timer;
	import pwm_capture_pkg::*;
	logic core_clk, rst, reg_wr, reg_rd;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata_r, d;
	logic [CHANNELS-1:0] cap_pin, pwm_a, pwm_b, irq_r, cap_flag_r;
	int fails = 0, n_compared = 0;
	int hi, lo, p, pr, cm, dv, tk, c0, e, v;
	int mdl[128];
	pwm_capture_timer u_pwm_capture_timer (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .cap_pin(cap_pin),
		.pwm_a(pwm_a), .pwm_b(pwm_b), .irq_r(irq_r),
		.cap_flag_r(cap_flag_r));
	// ****************
	// tasks
	// ****************
	task automatic chk(input string n, input logic [31:0] x, y);
		n_compared++;
		if (y !== x) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic chk_cnt(input string n, input int x, y);
		n_compared++;
		if (y != x) begin
			fails++;
			$display("MISMATCH %s expected %0d seen %0d", n, x, y);
		end
	endtask
	// read-only and unmapped places model as zero
	function automatic logic [31:0] msk(input int a);
		if (a >= 64)
			return 32'h0;
		case (a % 8)
		0: return 32'h77f;
		1, 5: return 32'hff;
		2, 3, 4: return 32'hffff;
		default: return 32'h0;
		endcase
	endfunction
	task automatic wr(input int a, input logic [31:0] x);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a[6:0];
		reg_wdata <= x;
		mdl[a] = x & msk(a);
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input int a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a[6:0];
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_r;
	endtask
	task automatic run(input int ch, input bit b, input bit x, output int n);
		n = 0;
		while ((b ? pwm_b[ch] : pwm_a[ch]) === x && n < 4000) begin
			n++;
			@(posedge core_clk);
			#1;
		end
	endtask
	// two skips so a reconfigured channel settles before measuring
	task automatic meas(input int ch, input bit b);
		#1;
		run(ch, b, 1, hi);
		run(ch, b, 0, hi);
		run(ch, b, 1, hi);
		run(ch, b, 0, lo);
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		#1_500_000;
		fails++;
		end_of_test();
	end
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		cap_pin = '0;
		p = $urandom(32'h4aa97f05);
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int a = 0; a < 66; a++) begin
			rd(a);
			chk("reset value", mdl[a], d);
		end
		for (int a = 0; a < 66; a++)
			wr(a, $urandom & 32'hfffffffc);
		for (int a = 0; a < 66; a++) begin
			rd(a);
			chk("register", mdl[a], d);
		end
		$display("test registers done");
		for (dv = 0; dv < 5; dv++) begin
			p = $urandom_range(3);
			pr = $urandom_range(9, 3);
			cm = $urandom_range(pr - 1, 1);
			tk = (p + 1) << dv;
			wr(0, 0);
			wr(1, p);
			wr(2, pr);
			wr(3, cm);
			wr(4, pr - cm);
			wr(0, 1 | dv << 8);
			meas(0, 0);
			chk_cnt("a high", tk * cm, hi);
			chk_cnt("period", tk * (pr + 1), hi + lo);
			meas(0, 1);
			chk_cnt("b high", tk * (pr - cm), hi);
		end
		// divider code 7 must act as /16, so tk of the last pass holds
		wr(0, 32'h705);
		meas(0, 0);
		chk_cnt("inverted high", tk * (pr + 1 - cm), hi);
		wr(0, 32'hc);
		repeat (3) @(posedge core_clk);
		#1;
		chk("idle levels", 2'b11, {pwm_b[0], pwm_a[0]});
		rd(64);
		chk("wrap flag", 1, d);
		chk("wrap port", 32'h1, irq_r);
		wr(64, 32'hff);
		rd(64);
		chk("flag clear", 0, d);
		chk("wrap port clear", 32'h0, irq_r);
		$display("test timer done");
		p = $urandom_range(3);
		wr(9, 0);
		wr(10, 20);
		wr(11, 8);
		wr(13, p);
		wr(8, 3);
		meas(1, 0);
		chk_cnt("dead a", 7 - p, hi);
		meas(1, 1);
		chk_cnt("dead b", 12 - p, hi);
		wr(8, 0);
		$display("test dead time done");
		wr(17, 0);
		wr(18, 32'hffff);
		for (e = 0; e < 4; e++) begin
			wr(16, 32'h11 | e << 5);
			for (v = 1; v >= 0; v--) begin
				wr(64, 32'hff00);
				rd(23);
				c0 = d;
				@(posedge core_clk);
				cap_pin[2] <= v[0];
				repeat (6) @(posedge core_clk);
				#1;
				chk("capture flag", e > 1 || e == !v, cap_flag_r[2]);
				rd(22);
				if (e > 1 || e == !v)
					chk_cnt("lag", 1, d - c0 inside {[1:12]});
			end
		end
		$display("test capture done");
		end_of_test();
	end
endmodule
`default_nettype wire
